// ===== isb_assertions.sv
/* Port checker for isb_top, bound after the module.
   Assumes one clock domain and a one-cycle rti_exec pulse from the core. */
`timescale 1ns/1ns
module isb_assertions #(
	parameter logic [7:0] TRAP_OPCODE = 8'h83
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic break_req,
	input wire logic break_match,
	input wire logic instr_last,
	input wire logic monitor_mode,
	input wire logic rti_exec,
	input wire logic force_ir,
	input wire logic [7:0] force_opcode,
	input wire logic pc_load,
	input wire logic [15:0] pc_vector,
	input wire logic break_active,
	input wire logic svc_valid,
	input wire logic [15:0] svc_vector,
	input wire logic [4:0] svc_flag
);
	// ==========
	// Address of the read answer in flight
	logic [7:0] rd_a_ff;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			rd_a_ff <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rd_a_ff <= s_axi_araddr;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ==========
	// Properties
	property p_trap; force_ir |-> force_opcode == TRAP_OPCODE && pc_load; endproperty
	a_trap: assert property (p_trap) else $error("trap entry malformed");
	property p_vec; pc_load |-> pc_vector == ($past(monitor_mode) ? 16'hFEFC : 16'hFFFC); endproperty
	a_vec: assert property (p_vec) else $error("wrong break vector");
	property p_defer; force_ir |-> $past(instr_last); endproperty
	a_defer: assert property (p_defer) else $error("break entered mid instruction");
	property p_now; break_match && instr_last && !break_active |=> force_ir; endproperty
	a_now: assert property (p_now) else $error("break entry late");
	property p_exit; break_active && rti_exec && !break_req |=> !break_active; endproperty
	a_exit: assert property (p_exit) else $error("break not left");
	property p_hold; break_active && !(rti_exec && !break_req) |=> break_active; endproperty
	a_hold: assert property (p_hold) else $error("break left early");
	property p_st1; s_axi_rvalid && rd_a_ff == 8'h00 |-> s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_st1: assert property (p_st1) else $error("status one spare bits set");
	property p_st3; s_axi_rvalid && rd_a_ff == 8'h08 |-> s_axi_rdata[31:7] == 25'h0; endproperty
	a_st3: assert property (p_st3) else $error("status three spare bits set");
	property p_v6; svc_valid && svc_flag == 5'h06 |-> svc_vector == 16'hFFF0; endproperty
	a_v6: assert property (p_v6) else $error("flag 6 vector wrong");
	property p_v8; svc_valid && svc_flag == 5'h08 |-> svc_vector == 16'hFFEC; endproperty
	a_v8: assert property (p_v8) else $error("flag 8 vector wrong");
	property p_v4; svc_valid && svc_flag == 5'h04 |-> svc_vector == 16'hFFF4; endproperty
	a_v4: assert property (p_v4) else $error("flag 4 vector wrong");
	property p_vr; svc_valid && svc_flag == 5'h00 |-> svc_vector == 16'hFFFE; endproperty
	a_vr: assert property (p_vr) else $error("reset vector wrong");
	c_entry: cover property (force_ir);
	c_exit: cover property ($fell(break_active));
	c_v6: cover property (svc_valid && svc_flag == 5'h06);
endmodule : isb_assertions

bind isb_top isb_assertions #(.TRAP_OPCODE(TRAP_OPCODE)) isb_assertions_i (
	.clk_sys(clk_sys), .reset(reset), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.break_req(break_req), .break_match(break_match), .instr_last(instr_last),
	.monitor_mode(monitor_mode), .rti_exec(rti_exec), .force_ir(force_ir), .force_opcode(force_opcode),
	.pc_load(pc_load), .pc_vector(pc_vector), .break_active(break_active), .svc_valid(svc_valid),
	.svc_vector(svc_vector), .svc_flag(svc_flag)
);

// ===== isb_axil.sv
/*
 * AXI4-Lite slave front end: one write and one read in flight at most.
 * Assumes the parent decodes the address and returns read data and a
 * hit flag in the same cycle as the request strobe.
 */
`timescale 1ns/1ns
`include "isb_map.svh"

module isb_axil (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_go,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	output logic rd_go,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit
);
	logic awready_ff, wready_ff, arready_ff;
	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	wire aw_hs = s_axi_awvalid & awready_ff;
	wire w_hs = s_axi_wvalid & wready_ff;
	wire ar_hs = s_axi_arvalid & arready_ff;

	assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign wr_addr = awaddr_ff;
	assign wr_data = wdata_ff;
	assign wr_strb = wstrb_ff;
	assign rd_go = ar_hs;
	assign rd_addr = s_axi_araddr;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// ==========================================================
	// Write channels, taken in either order
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `ISB_RESP_OKAY;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end else if (!aw_got_ff && !bvalid_ff) begin
				awready_ff <= 1'b1;
			end
			if (w_hs) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end else if (!w_got_ff && !bvalid_ff) begin
				wready_ff <= 1'b1;
			end
			if (wr_go) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? `ISB_RESP_OKAY : `ISB_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read channel: data captured at the address handshake
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rresp_ff <= `ISB_RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (ar_hs) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_hit ? rd_data : 32'h00000000;
			rresp_ff <= rd_hit ? `ISB_RESP_OKAY : `ISB_RESP_SLVERR;
		end else if (rvalid_ff) begin
			if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end else begin
			arready_ff <= 1'b1;
		end
	end

endmodule : isb_axil

// ===== isb_core_model.sv
/* Behavioural core: fixed-length instructions and a vector fetcher.
   Assumes svc outputs of isb_top are registered. */
`timescale 1ns/1ns
module isb_core_model #(
	parameter int INSTR_LEN = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic svc_valid,
	input wire logic [15:0] svc_vector,
	output logic instr_last,
	output logic near_last,
	output logic vec_taken,
	output logic [15:0] taken_vec
);
	// ==========
	// Instruction counter; near_last lets the bench aim at a last cycle
	logic [3:0] cnt_ff;
	logic take_ff;
	logic [15:0] vec_ff;
	assign instr_last = cnt_ff == 4'(INSTR_LEN - 1);
	assign near_last = cnt_ff == 4'(INSTR_LEN - 2);
	assign vec_taken = take_ff;
	assign taken_vec = vec_ff;
	// Fetch takes a cycle, so the block sees the slow answer a real core gives
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_ff <= 4'h0;
			take_ff <= 1'b0;
			vec_ff <= 16'h0000;
		end else begin
			cnt_ff <= instr_last ? 4'h0 : cnt_ff + 4'h1;
			take_ff <= svc_valid && !take_ff;
			if (svc_valid && !take_ff)
				vec_ff <= svc_vector;
		end
	end
endmodule : isb_core_model

// ===== isb_map.svh
/*
 * Offsets, field positions, reset values and vector addresses for the
 * interrupt status and break entry block.
 * Assumes a 32-bit AXI4-Lite register window with one register per word.
 */
`ifndef ISB_MAP_SVH
`define ISB_MAP_SVH

// ==========================================================
// Register byte offsets
`define ISB_OFS_PEND1 8'h00
`define ISB_OFS_PEND2 8'h04
`define ISB_OFS_PEND3 8'h08
`define ISB_OFS_EVT 8'h0C
`define ISB_OFS_MASK 8'h10
`define ISB_OFS_CTRL 8'h14
`define ISB_OFS_STATE 8'h18

// ==========================================================
// Field positions and reset values
`define ISB_EVT_W 3
`define ISB_EVT_ENTER 0
`define ISB_EVT_EXIT 1
`define ISB_EVT_NEWREQ 2
`define ISB_CTRL_BRK_EN 0
`define ISB_CTRL_SVC_EN 1
`define ISB_CTRL_RST 2'h3
`define ISB_MASK_RST 3'h0

// ==========================================================
// Vector addresses (high byte; low byte follows)
`define ISB_VEC_RESET 16'hFFFE
`define ISB_VEC_TRAP 16'hFFFC
`define ISB_VEC_TRAP_MON 16'hFEFC
`define ISB_VEC_T1_CH0 16'hFFF4
`define ISB_VEC_T1_OVF 16'hFFF0
`define ISB_VEC_T2_CH1 16'hFFEC

// ==========================================================
// Bus responses
`define ISB_RESP_OKAY 2'h0
`define ISB_RESP_SLVERR 2'h2

`endif

// ===== isb_pkg.sv
/*
 * Types shared by the interrupt status and break entry block.
 * Assumes isb_map.svh supplies all numeric constants.
 */
package isb_pkg;

	// ==========================================================
	// Break sequencer states
	typedef enum logic [1:0] {
		ISB_IDLE = 2'b00,
		ISB_DEFER = 2'b01,
		ISB_ACTIVE = 2'b10
	} isb_brk_st_t;

endpackage : isb_pkg

// ===== isb_top.sv
/*
 * Interrupt pending status and break entry logic for an 8-bit core.
 * Reports source request levels in three status registers, selects the
 * vector of the highest priority request, and sequences break entry
 * and exit for the core.
 * Assumes source request lines and core handshakes are synchronous to
 * clk_sys and that the core marks the last cycle of each instruction.
 */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "isb_map.svh"

module isb_top #(
	parameter int NUM_SRC = 21,
	parameter logic [7:0] TRAP_OPCODE = 8'h83
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_SRC:1] src_req,
	input wire logic break_req,
	input wire logic break_match,
	input wire logic instr_last,
	input wire logic monitor_mode,
	input wire logic rti_exec,
	input wire logic vec_taken,
	output logic force_ir,
	output logic [7:0] force_opcode,
	output logic pc_load,
	output logic [15:0] pc_vector,
	output logic break_active,
	output logic svc_valid,
	output logic [15:0] svc_vector,
	output logic [4:0] svc_flag,
	output logic irq_out
);
	// ==========================================================
	// Bus front end
	logic wr_go, wr_hit, rd_go, rd_hit;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;

	isb_axil isb_axil_i (
		.clk_sys(clk_sys),
		.reset(reset),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_go(wr_go),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_go(rd_go),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// ==========================================================
	// Registered state
	logic [NUM_SRC:1] req_ff;
	logic [`ISB_EVT_W-1:0] evt_ff, mask_ff;
	logic [1:0] ctrl_ff;
	isb_pkg::isb_brk_st_t brk_st_ff, nxt_brk_st;
	logic force_ir_ff, pc_load_ff, brk_act_ff;
	logic [15:0] pc_vec_ff;
	logic rst_vec_ff;
	logic svc_valid_ff;
	logic [15:0] svc_vec_ff;
	logic [4:0] svc_flag_ff;
	logic irq_ff;

	// ==========================================================
	// Status register images
	// Flags are request levels, not latched; the source holds its request
	// until serviced, so no clear path exists here.
	wire [7:0] pend1 = {req_ff[6:1], 2'b00};
	wire [7:0] pend2 = req_ff[14:7];
	wire [7:0] pend3 = {1'b0, req_ff[21:15]};

	// ==========================================================
	// Address decode
	wire rd_p1 = rd_addr == `ISB_OFS_PEND1;
	wire rd_p2 = rd_addr == `ISB_OFS_PEND2;
	wire rd_p3 = rd_addr == `ISB_OFS_PEND3;
	wire rd_ev = rd_addr == `ISB_OFS_EVT;
	wire rd_mk = rd_addr == `ISB_OFS_MASK;
	wire rd_ct = rd_addr == `ISB_OFS_CTRL;
	wire rd_stt = rd_addr == `ISB_OFS_STATE;
	assign rd_hit = rd_p1 | rd_p2 | rd_p3 | rd_ev | rd_mk | rd_ct | rd_stt;

	wire wr_ev = wr_go & (wr_addr == `ISB_OFS_EVT) & wr_strb[0];
	wire wr_mk = wr_go & (wr_addr == `ISB_OFS_MASK) & wr_strb[0];
	wire wr_ct = wr_go & (wr_addr == `ISB_OFS_CTRL) & wr_strb[0];
	// Status words are read only; writes to them are accepted and dropped
	wire wr_ro = (wr_addr == `ISB_OFS_PEND1) | (wr_addr == `ISB_OFS_PEND2)
		| (wr_addr == `ISB_OFS_PEND3) | (wr_addr == `ISB_OFS_STATE);
	assign wr_hit = wr_ro | (wr_addr == `ISB_OFS_EVT)
		| (wr_addr == `ISB_OFS_MASK) | (wr_addr == `ISB_OFS_CTRL);

	wire [7:0] state_img = {5'h00, brk_act_ff, brk_st_ff};
	assign rd_data = rd_p1 ? {24'h000000, pend1} :
		rd_p2 ? {24'h000000, pend2} :
		rd_p3 ? {24'h000000, pend3} :
		rd_ev ? {29'h00000000, evt_ff} :
		rd_mk ? {29'h00000000, mask_ff} :
		rd_ct ? {30'h00000000, ctrl_ff} :
		rd_stt ? {24'h000000, state_img} : 32'h00000000;

	// ==========================================================
	// Request sampling
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			req_ff <= '0;
		end else begin
			req_ff <= src_req;
		end
	end

	// ==========================================================
	// Break sequencer
	wire brk_en = ctrl_ff[`ISB_CTRL_BRK_EN];
	// Match on a last cycle enters immediately; otherwise wait for the end
	wire enter_now = break_match & instr_last;
	wire brk_start = (brk_st_ff == isb_pkg::ISB_IDLE) & brk_en
		& (enter_now | (break_req & instr_last));
	wire brk_defer = (brk_st_ff == isb_pkg::ISB_IDLE) & brk_en
		& (break_req | break_match) & ~instr_last;
	wire brk_resume = (brk_st_ff == isb_pkg::ISB_DEFER) & instr_last;
	wire brk_enter = brk_start | brk_resume;
	// A handler return with the request still high keeps the break state
	wire brk_leave = (brk_st_ff == isb_pkg::ISB_ACTIVE)
		& rti_exec & ~break_req;

	always_comb begin
		nxt_brk_st = brk_st_ff;
		unique case (brk_st_ff)
			isb_pkg::ISB_IDLE: begin
				if (brk_start) begin
					nxt_brk_st = isb_pkg::ISB_ACTIVE;
				end else if (brk_defer) begin
					nxt_brk_st = isb_pkg::ISB_DEFER;
				end
			end
			isb_pkg::ISB_DEFER: begin
				if (brk_resume) begin
					nxt_brk_st = isb_pkg::ISB_ACTIVE;
				end
			end
			isb_pkg::ISB_ACTIVE: begin
				if (brk_leave) begin
					nxt_brk_st = isb_pkg::ISB_IDLE;
				end
			end
			default: begin
				nxt_brk_st = isb_pkg::ISB_IDLE;
			end
		endcase
	end

	// Monitor mode picks the alternate trap vector
	wire [15:0] trap_vec = monitor_mode ? `ISB_VEC_TRAP_MON
		: `ISB_VEC_TRAP;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			brk_st_ff <= isb_pkg::ISB_IDLE;
			brk_act_ff <= 1'b0;
			force_ir_ff <= 1'b0;
			pc_load_ff <= 1'b0;
			pc_vec_ff <= 16'h0000;
		end else begin
			brk_st_ff <= nxt_brk_st;
			brk_act_ff <= nxt_brk_st == isb_pkg::ISB_ACTIVE;
			force_ir_ff <= brk_enter;
			pc_load_ff <= brk_enter;
			if (brk_enter) begin
				pc_vec_ff <= trap_vec;
			end
		end
	end

	// ==========================================================
	// Vector selection
	// Flag n vectors at FFFC - 2n, so a lower flag number sits higher
	// and wins; the loop keeps the lowest pending number.
	logic [4:0] win_num;
	logic win_any;
	logic [15:0] src_vec [1:NUM_SRC];

	genvar gi;
	generate
		for (gi = 1; gi <= NUM_SRC; gi++) begin : g_vec
			// Covers FFF4 for flag 4, FFF0 for flag 6, FFEC for flag 8
			assign src_vec[gi] = `ISB_VEC_TRAP
				- 16'(2 * gi);
		end
	endgenerate

	always_comb begin
		win_num = 5'h00;
		win_any = 1'b0;
		for (int i = NUM_SRC; i >= 1; i--) begin
			if (req_ff[i]) begin
				win_num = 5'(i);
				win_any = 1'b1;
			end
		end
	end

	wire svc_en = ctrl_ff[`ISB_CTRL_SVC_EN];
	// Sources are held off during a break; the trap owns the core then
	wire svc_open = svc_en & win_any & (brk_st_ff == isb_pkg::ISB_IDLE);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rst_vec_ff <= 1'b1;
			svc_valid_ff <= 1'b0;
			svc_vec_ff <= 16'h0000;
			svc_flag_ff <= 5'h00;
		end else begin
			if (vec_taken && rst_vec_ff) begin
				rst_vec_ff <= 1'b0;
			end
			if (rst_vec_ff && !vec_taken) begin
				svc_valid_ff <= 1'b1;
				svc_vec_ff <= `ISB_VEC_RESET;
				svc_flag_ff <= 5'h00;
			end else if (svc_open) begin
				svc_valid_ff <= 1'b1;
				svc_vec_ff <= src_vec[win_num];
				svc_flag_ff <= win_num;
			end else begin
				svc_valid_ff <= 1'b0;
				svc_vec_ff <= 16'h0000;
				svc_flag_ff <= 5'h00;
			end
		end
	end

	// ==========================================================
	// Event status, mask and control
	wire new_req = |(src_req & ~req_ff);
	wire [`ISB_EVT_W-1:0] evt_set = {new_req, brk_leave, brk_enter};
	wire [`ISB_EVT_W-1:0] evt_clr = wr_ev ? wr_data[`ISB_EVT_W-1:0] : '0;
	// Set beats clear so an event in the clearing cycle survives
	wire [`ISB_EVT_W-1:0] nxt_evt = (evt_ff & ~evt_clr) | evt_set;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			evt_ff <= '0;
			mask_ff <= `ISB_MASK_RST;
			ctrl_ff <= `ISB_CTRL_RST;
			irq_ff <= 1'b0;
		end else begin
			evt_ff <= nxt_evt;
			if (wr_mk) begin
				mask_ff <= wr_data[`ISB_EVT_W-1:0];
			end
			if (wr_ct) begin
				ctrl_ff <= wr_data[1:0];
			end
			irq_ff <= |(nxt_evt & mask_ff);
		end
	end

	// ==========================================================
	// Outputs
	assign force_ir = force_ir_ff;
	assign force_opcode = TRAP_OPCODE;
	assign pc_load = pc_load_ff;
	assign pc_vector = pc_vec_ff;
	assign break_active = brk_act_ff;
	assign svc_valid = svc_valid_ff;
	assign svc_vector = svc_vec_ff;
	assign svc_flag = svc_flag_ff;
	assign irq_out = irq_ff;

endmodule : isb_top

// ===== isb_top_tb.sv
/* Self-checking bench for isb_top over AXI4-Lite.
   Assumes isb_core_model stands in for the core. */
`timescale 1ns/1ns
module isb_top_tb;
	localparam int LEN = 4;
	localparam logic [7:0] TRAP = 8'h83;
	localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	localparam logic [31:0] RV [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h0};
	localparam logic [21:1] SP [7] = '{21'h000020, 21'h000080, 21'h000008, 21'h0000A8,
		21'h1FFFFF, 21'h155555, 21'h0AAAAA};
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [21:1] src = 21'h0;
	logic brq = 1'b0, bmatch = 1'b0, mon = 1'b0, return_from_handler_opcode = 1'b0;
	logic ilast, nlast, vtk, fir, pcl, bact, svcv, irq;
	logic [7:0] fop;
	logic [15:0] pcv, svec, tvec;
	logic [4:0] sflag;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;

	isb_top #(.NUM_SRC(21), .TRAP_OPCODE(TRAP)) isb_top_i (
		.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_req(src),
		.break_req(brq), .break_match(bmatch), .instr_last(ilast), .monitor_mode(mon),
		.rti_exec(return_from_handler_opcode), .vec_taken(vtk), .force_ir(fir), .force_opcode(fop), .pc_load(pcl),
		.pc_vector(pcv), .break_active(bact), .svc_valid(svcv), .svc_vector(svec),
		.svc_flag(sflag), .irq_out(irq)
	);
	isb_core_model #(.INSTR_LEN(LEN)) isb_core_model_i (
		.clk_sys(clk_sys), .reset(reset), .svc_valid(svcv), .svc_vector(svec),
		.instr_last(ilast), .near_last(nlast), .vec_taken(vtk), .taken_vec(tvec)
	);

	always #4 clk_sys = ~clk_sys;

	// ==========
	// Shared tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("Checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// Write and read keep bready and rready high, so each ends on the answer edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Only the bench timeout ends a wait for the answer
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		check("bresp", {30'h0, bresp}, {30'h0, er});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		check("rresp", {30'h0, rresp}, {30'h0, er});
	endtask : axi_rd

	// Aims a request at the last cycle or at the first cycle of an instruction
	task automatic entry(input logic use_req, input logic at_last, input int exp_n, input logic [15:0] vec);
		int n;
		n = 0;
		do @(posedge clk_sys); while (!(at_last ? nlast : ilast));
		if (use_req) brq <= 1'b1;
		else bmatch <= 1'b1;
		@(posedge clk_sys);
		bmatch <= 1'b0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!fir && n < 20);
		check("entry delay", n, exp_n);
		check("opcode", {24'h0, fop}, {24'h0, TRAP});
		check("pc vector", {16'h0, pcv}, {16'h0, vec});
		check("pc load", {31'h0, pcl}, 32'h1);
		check("break on", {31'h0, bact}, 32'h1);
	endtask : entry

	task automatic do_rti(input logic stay);
		@(posedge clk_sys);
		return_from_handler_opcode <= 1'b1;
		@(posedge clk_sys);
		return_from_handler_opcode <= 1'b0;
		@(posedge clk_sys);
		check("break after return", {31'h0, bact}, {31'h0, stay});
	endtask : do_rti

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end

	// ==========
	// Main sequence
	initial begin
		logic [31:0] d;
		int f;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check("reset vector", {16'h0, tvec}, 32'h0000FFFE);
		for (int i = 0; i < 7; i++) begin
			axi_rd(RA[i], d, 2'h0);
			check("reset value", d, RV[i]);
		end
		axi_rd(8'h20, d, 2'h2);
		check("unmapped data", d, 32'h0);
		axi_wr(8'h20, 32'h1, 2'h2);
		axi_wr(8'h04, 32'hFF, 2'h0);
		axi_rd(8'h04, d, 2'h0);
		check("status 2 read only", d, 32'h0);
		entry(1'b0, 1'b1, 1, 16'hFFFC);
		do_rti(1'b0);
		mon <= 1'b1;
		entry(1'b1, 1'b0, LEN, 16'hFEFC);
		do_rti(1'b1);
		brq <= 1'b0;
		do_rti(1'b0);
		mon <= 1'b0;
		check("irq masked", {31'h0, irq}, 32'h0);
		axi_rd(8'h0C, d, 2'h0);
		check("events", d, 32'h3);
		axi_wr(8'h10, 32'h7, 2'h0);
		repeat (2) @(posedge clk_sys);
		check("irq raised", {31'h0, irq}, 32'h1);
		axi_wr(8'h0C, 32'h7, 2'h0);
		axi_rd(8'h0C, d, 2'h0);
		check("events cleared", d, 32'h0);
		repeat (2) @(posedge clk_sys);
		check("irq cleared", {31'h0, irq}, 32'h0);
		// Lowest flag holds the highest vector and wins
		for (int i = 0; i < 7; i++) begin
			src <= SP[i];
			repeat (3) @(posedge clk_sys);
			f = 0;
			for (int k = 21; k >= 1; k--) if (SP[i][k]) f = k;
			check("svc flag", {26'h0, svcv, sflag}, {26'h0, 1'b1, 5'(f)});
			check("svc vector", {16'h0, svec}, 32'h0000FFFC - 32'(2 * f));
			axi_rd(8'h00, d, 2'h0);
			check("status 1", d, {24'h0, src[6:1], 2'h0});
			axi_rd(8'h04, d, 2'h0);
			check("status 2", d, {24'h0, src[14:7]});
			axi_rd(8'h08, d, 2'h0);
			check("status 3", d, {25'h0, src[21:15]});
		end
		check("irq on new request", {31'h0, irq}, 32'h1);
		axi_rd(8'h0C, d, 2'h0);
		check("new request event", d, 32'h4);
		// Service off: flags stay pending but no vector is offered
		axi_wr(8'h14, 32'h1, 2'h0);
		repeat (2) @(posedge clk_sys);
		check("svc withheld", {31'h0, svcv}, 32'h0);
		// Mid-run reset brings back the reset vector and the control default
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check("reset vector again", {16'h0, tvec}, 32'h0000FFFE);
		axi_rd(8'h14, d, 2'h0);
		check("control after reset", d, 32'h3);
		complete_run();
	end
endmodule : isb_top_tb
